/* File: design/bcd_converter.sv */
// binary to packed decimal by shift and add three
`timescale 1ns/1ns
module bcd_converter
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// request
	input  wire logic        start,
	input  wire logic [23:0] bin,
	// answer
	output logic             done,
	output logic [31:0]      digits
);
	logic [23:0] sh_reg;
	logic [4:0]  cnt_reg;
	logic [31:0] adj;

	// add three to every digit above four before the shift
	always_comb
	begin
		adj = digits;
		for (int i = 0; i < 8; i++)
		begin
			if (digits[4*i +: 4] > 4'h4)
				adj[4*i +: 4] = digits[4*i +: 4] + 4'h3;
		end
	end

	// shift loop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sh_reg  <= 24'h0;
			cnt_reg <= 5'h0;
			digits  <= 32'h0;
			done    <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				sh_reg  <= bin;
				digits  <= 32'h0;
				cnt_reg <= 5'h18;
			end
			else if (cnt_reg != 5'h0)
			begin
				digits  <= {adj[30:0], sh_reg[23]};
				sh_reg  <= {sh_reg[22:0], 1'b0};
				cnt_reg <= cnt_reg - 5'h1;
				done    <= (cnt_reg == 5'h1);
			end
		end
	end
endmodule

/* File: design/measurement_output_formatter.sv */
// formats distance results for the serial link and the analogue output
`timescale 1ns/1ns
module measurement_output_formatter
	import formatter_pkg::*;
(
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// measurement results
	input  wire logic        MEAS_VALID,
	input  wire logic [31:0] MEAS_DIST,
	input  wire logic [7:0]  MEAS_STRENGTH,
	input  wire logic [7:0]  MEAS_TEMP,
	// serial byte stream
	output logic [7:0]       TX_DATA,
	output logic             TX_VALID,
	input  wire logic        TX_READY,
	// analogue current
	output logic [14:0]      ANALOG_UA,
	output logic             ANALOG_UPDATE
);
	import formatter_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_SEND} state_type;

	state_type   state_reg;
	logic [1:0]  fmt_reg, fmt_lat;
	logic [1:0]  content_reg, content_lat;
	logic [3:0]  term_reg, term_lat;
	logic [31:0] unit_reg, lo_reg, hi_reg, lo_stage_reg;
	logic [31:0] win_start_reg, win_end_reg;
	logic        win_mode_reg;
	logic [31:0] drops_reg;
	logic [31:0] dist_reg;
	logic [7:0]  str_reg, temp_reg;
	logic        err_reg, below_reg;
	logic [7:0]  msg_reg [0:MSG_MAX-1];
	logic [7:0]  msg_next [0:MSG_MAX-1];
	logic [4:0]  len_reg, len_next, idx_reg;
	logic        in_win, frame_req, accept, ana_start;
	logic        bin_busy, bin_done, ana_busy, ana_done, bcd_done;
	logic [47:0] bin_q, ana_q;
	logic [31:0] bcd_digits, dist_abs, span_abs, delta_abs;
	logic [32:0] delta, span;
	logic        wr, rd_setup;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] abs32(input logic [31:0] v);
		return v[31] ? (~v + 32'h1) : v;
	endfunction

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < 4'ha) ? (CH_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	function automatic logic [7:0] term_char(input logic [3:0] sel);
		case (sel)
			4'h0: term_char = 8'h0d; // second byte added separately
			4'h1: term_char = 8'h0d;
			4'h2: term_char = 8'h0a;
			4'h3: term_char = 8'h02;
			4'h4: term_char = 8'h03;
			4'h5: term_char = 8'h09;
			4'h6: term_char = 8'h20;
			4'h7: term_char = 8'h2c;
			4'h8: term_char = 8'h3a;
			default: term_char = 8'h3b;
		endcase
	endfunction

	// ----------------------------------------
	// apb register access
	// ----------------------------------------
	assign PREADY   = 1'b1;
	assign wr       = PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE;

	// unmapped offsets answer with an error
	always_comb
	begin
		PSLVERR = PSEL && PENABLE && (PADDR[1:0] != 2'h0 || PADDR > OFS_STATUS);
	end

	// settings written by software
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			fmt_reg       <= FMT_DEC;
			content_reg   <= 2'h0;
			term_reg      <= TERM_RST;
			unit_reg      <= UNIT_RST;
			lo_reg        <= ALIM_LO_RST;
			hi_reg        <= ALIM_HI_RST;
			lo_stage_reg  <= ALIM_LO_RST;
			win_start_reg <= WIN_START_RST;
			win_end_reg   <= WIN_END_RST;
			win_mode_reg  <= 1'b0;
		end
		else if (wr)
		begin
			case (PADDR)
				OFS_FORMAT:
					if (PWDATA[FMT_LSB +: 2] <= FMT_BIN)
					begin
						fmt_reg     <= PWDATA[FMT_LSB +: 2];
						content_reg <= PWDATA[CONTENT_LSB +: 2];
					end
				OFS_TERM:
					if (PWDATA <= TERM_MAX)
						term_reg <= PWDATA[3:0];
				OFS_UNIT:
					if (PWDATA != 32'h0)
						unit_reg <= PWDATA;
				OFS_ALIM_LO:
					lo_stage_reg <= PWDATA;
				OFS_ALIM_HI:
					if (PWDATA != lo_stage_reg)
					begin
						lo_reg <= lo_stage_reg;
						hi_reg <= PWDATA;
					end
				OFS_WIN_START:
					win_start_reg <= PWDATA;
				OFS_WIN_END:
					win_end_reg <= PWDATA;
				OFS_WIN_MODE:
					win_mode_reg <= PWDATA[0];
				default:
					win_mode_reg <= win_mode_reg;
			endcase
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			PRDATA <= 32'h0;
		else if (rd_setup)
		begin
			case (PADDR)
				OFS_FORMAT:    PRDATA <= {28'h0, content_reg, fmt_reg};
				OFS_TERM:      PRDATA <= {28'h0, term_reg};
				OFS_UNIT:      PRDATA <= unit_reg;
				OFS_ALIM_LO:   PRDATA <= lo_reg;
				OFS_ALIM_HI:   PRDATA <= hi_reg;
				OFS_WIN_START: PRDATA <= win_start_reg;
				OFS_WIN_END:   PRDATA <= win_end_reg;
				OFS_WIN_MODE:  PRDATA <= {31'h0, win_mode_reg};
				OFS_ANALOG:    PRDATA <= {17'h0, ANALOG_UA};
				OFS_DROPS:     PRDATA <= drops_reg;
				OFS_STATUS:    PRDATA <= {30'h0, ana_busy, state_reg != ST_IDLE};
				default:       PRDATA <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------
	// window check and frame acceptance
	// ----------------------------------------
	always_comb
	begin
		in_win = ($signed(MEAS_DIST) >= $signed(win_start_reg)) &&
			($signed(MEAS_DIST) <= $signed(win_end_reg));
		frame_req = MEAS_VALID && (in_win || (!win_mode_reg && fmt_reg != FMT_BIN));
		accept    = frame_req && state_reg == ST_IDLE;
		ana_start = MEAS_VALID && in_win && !ana_busy;
	end

	// results that arrive while a frame is in flight are counted and lost
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			drops_reg <= 32'h0;
		else if (frame_req && state_reg != ST_IDLE)
			drops_reg <= drops_reg + 32'h1;
	end

	// latch the result and the settings for the whole frame
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			dist_reg    <= 32'h0;
			str_reg     <= 8'h0;
			temp_reg    <= 8'h0;
			err_reg     <= 1'b0;
			fmt_lat     <= FMT_DEC;
			content_lat <= 2'h0;
			term_lat    <= TERM_RST;
		end
		else if (accept)
		begin
			dist_reg    <= MEAS_DIST;
			str_reg     <= MEAS_STRENGTH;
			temp_reg    <= MEAS_TEMP;
			err_reg     <= !in_win;
			fmt_lat     <= fmt_reg;
			content_lat <= content_reg;
			term_lat    <= term_reg;
		end
	end

	// ----------------------------------------
	// conversions
	// ----------------------------------------
	assign dist_abs = abs32(MEAS_DIST);

	// binary distance: millimetres times 1000 over micrometres per bit
	serial_divider bin_div
	(
		.clk   (MCLK),
		.rst   (RST),
		.start (accept),
		.num   ({16'h0, dist_abs} * {32'h0, UM_PER_MM}),
		.den   (unit_reg),
		.busy  (bin_busy),
		.done  (bin_done),
		.quot  (bin_q)
	);

	// decimal digits of the saturated magnitude
	bcd_converter dec_conv
	(
		.clk    (MCLK),
		.rst    (RST),
		.start  (accept),
		.bin    ((dist_abs > {8'h0, DEC_MAX}) ? DEC_MAX : dist_abs[23:0]),
		.done   (bcd_done),
		.digits (bcd_digits)
	);

	// ----------------------------------------
	// message assembly
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] bin_s;
		logic [7:0]  t;
		bin_s = dist_reg[31] ? (~bin_q[31:0] + 32'h1) : bin_q[31:0];
		t = temp_reg + TEMP_OFFSET;
		len_next = 5'h0;
		for (int i = 0; i < MSG_MAX; i++)
			msg_next[i] = 8'h0;
		if (err_reg)
		begin
			msg_next[0] = 8'h45;
			msg_next[1] = 8'h52;
			msg_next[2] = 8'h52;
			len_next = 5'h3;
		end
		else if (fmt_lat == FMT_BIN)
		begin
			msg_next[0] = {1'b1, bin_s[13:7]};
			msg_next[1] = {1'b0, bin_s[6:0]};
			len_next = 5'h2;
			if (content_lat[0])
			begin
				msg_next[len_next] = {1'b0, str_reg[7:1]};
				len_next = len_next + 5'h1;
			end
			if (content_lat[1])
			begin
				msg_next[len_next] = {1'b0, t[7] ? 7'h0 : t[6:0]};
				len_next = len_next + 5'h1;
			end
		end
		else if (fmt_lat == FMT_HEX)
		begin
			for (int i = 0; i < 8; i++)
				msg_next[i] = hex_char(dist_reg[28 - 4*i +: 4]);
			len_next = 5'h8;
			if (content_lat[0])
			begin
				msg_next[len_next] = CH_SEP;
				msg_next[len_next + 5'h1] = hex_char(str_reg[7:4]);
				msg_next[len_next + 5'h2] = hex_char(str_reg[3:0]);
				len_next = len_next + 5'h3;
			end
			if (content_lat[1])
			begin
				msg_next[len_next] = CH_SEP;
				msg_next[len_next + 5'h1] = hex_char(temp_reg[7:4]);
				msg_next[len_next + 5'h2] = hex_char(temp_reg[3:0]);
				len_next = len_next + 5'h3;
			end
		end
		else
		begin
			msg_next[0] = dist_reg[31] ? CH_MINUS : CH_PLUS;
			for (int i = 0; i < DEC_DIGITS; i++)
				msg_next[i + 1] = hex_char(bcd_digits[24 - 4*i +: 4]);
			len_next = 5'h8;
			if (content_lat[0])
			begin
				msg_next[len_next] = CH_SEP;
				msg_next[len_next + 5'h1] = hex_char(4'(str_reg / 8'd100));
				msg_next[len_next + 5'h2] = hex_char(4'((str_reg / 8'd10) % 8'd10));
				msg_next[len_next + 5'h3] = hex_char(4'(str_reg % 8'd10));
				len_next = len_next + 5'h4;
			end
			if (content_lat[1])
			begin
				t = temp_reg[7] ? (~temp_reg + 8'h1) : temp_reg;
				msg_next[len_next] = CH_SEP;
				msg_next[len_next + 5'h1] = temp_reg[7] ? CH_MINUS : CH_PLUS;
				msg_next[len_next + 5'h2] = hex_char(4'(t / 8'd100));
				msg_next[len_next + 5'h3] = hex_char(4'((t / 8'd10) % 8'd10));
				msg_next[len_next + 5'h4] = hex_char(4'(t % 8'd10));
				len_next = len_next + 5'h5;
			end
		end
		if (fmt_lat != FMT_BIN)
		begin
			msg_next[len_next] = term_char(term_lat);
			len_next = len_next + 5'h1;
			if (term_lat == 4'h0)
			begin
				msg_next[len_next] = CH_LF;
				len_next = len_next + 5'h1;
			end
		end
	end

	// ----------------------------------------
	// frame sequencer and byte output
	// ----------------------------------------
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg <= ST_IDLE;
			len_reg   <= 5'h0;
			idx_reg   <= 5'h0;
			for (int i = 0; i < MSG_MAX; i++)
				msg_reg[i] <= 8'h0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (accept)
						state_reg <= ST_CONV;
				ST_CONV:
					if (bin_done) // decimal digits finish earlier
					begin
						msg_reg   <= msg_next;
						len_reg   <= len_next;
						idx_reg   <= 5'h0;
						state_reg <= ST_SEND;
					end
				ST_SEND:
					if (TX_READY)
					begin
						idx_reg <= idx_reg + 5'h1;
						if (idx_reg == len_reg - 5'h1)
							state_reg <= ST_IDLE;
					end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	assign TX_VALID = (state_reg == ST_SEND);
	assign TX_DATA  = msg_reg[idx_reg];

	// ----------------------------------------
	// analogue current
	// ----------------------------------------
	always_comb
	begin
		delta     = {MEAS_DIST[31], MEAS_DIST} - {lo_reg[31], lo_reg};
		span      = {hi_reg[31], hi_reg} - {lo_reg[31], lo_reg};
		delta_abs = delta[32] ? 32'(~delta + 33'h1) : delta[31:0];
		span_abs  = span[32] ? 32'(~span + 33'h1) : span[31:0];
	end

	serial_divider ana_div
	(
		.clk   (MCLK),
		.rst   (RST),
		.start (ana_start),
		.num   ({16'h0, delta_abs} * {33'h0, I_SPAN_UA}),
		.den   (span_abs),
		.busy  (ana_busy),
		.done  (ana_done),
		.quot  (ana_q)
	);

	// current below 4 mA clamps when distance lies on the wrong side
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			below_reg     <= 1'b0;
			ANALOG_UA     <= I_MIN_UA;
			ANALOG_UPDATE <= 1'b0;
		end
		else
		begin
			ANALOG_UPDATE <= ana_done;
			if (ana_start)
				below_reg <= (delta[32] ^ span[32]) && (delta != 33'h0);
			if (ana_done)
				ANALOG_UA <= below_reg ? I_MIN_UA :
					(ana_q > {33'h0, I_SPAN_UA}) ? I_MIN_UA + I_SPAN_UA :
					I_MIN_UA + ana_q[14:0];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_term_valid;
		@(posedge MCLK) disable iff (RST) term_reg <= TERM_MAX[3:0];
	endproperty
	a_term_valid: assert property (p_term_valid) else $error("bad terminator");

	property p_limits_differ;
		@(posedge MCLK) disable iff (RST) lo_reg != hi_reg;
	endproperty
	a_limits_differ: assert property (p_limits_differ) else $error("equal limits");

	property p_bin_high;
		@(posedge MCLK) disable iff (RST)
		TX_VALID && fmt_lat == FMT_BIN && idx_reg == 5'h0 |-> TX_DATA[7];
	endproperty
	a_bin_high: assert property (p_bin_high) else $error("high byte flag");

	property p_bin_rest;
		@(posedge MCLK) disable iff (RST)
		TX_VALID && fmt_lat == FMT_BIN && idx_reg != 5'h0 |-> !TX_DATA[7];
	endproperty
	a_bin_rest: assert property (p_bin_rest) else $error("low byte flag");

	property p_ascii_term;
		@(posedge MCLK) disable iff (RST)
		TX_VALID && fmt_lat != FMT_BIN && term_lat != 4'h0 && idx_reg == len_reg - 5'h1
		|-> TX_DATA == term_char(term_lat);
	endproperty
	a_ascii_term: assert property (p_ascii_term) else $error("terminator");

	property p_drop;
		@(posedge MCLK) disable iff (RST)
		frame_req && state_reg != ST_IDLE |=> drops_reg == $past(drops_reg) + 32'h1;
	endproperty
	a_drop: assert property (p_drop) else $error("drop not counted");

	property p_analog_range;
		@(posedge MCLK) disable iff (RST)
		ANALOG_UPDATE |-> ANALOG_UA >= I_MIN_UA && ANALOG_UA <= I_MIN_UA + I_SPAN_UA;
	endproperty
	a_analog_range: assert property (p_analog_range) else $error("current range");

	property p_analog_latency;
		@(posedge MCLK) disable iff (RST)
		ana_start |-> ##49 ana_done ##1 ANALOG_UPDATE;
	endproperty
	a_analog_latency: assert property (p_analog_latency) else $error("analog late");

	property p_frame_start;
		@(posedge MCLK) disable iff (RST)
		accept |-> ##[49:50] TX_VALID;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame late");
endmodule

/* File: design/serial_divider.sv */
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ns
module serial_divider
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// request
	input  wire logic        start,
	input  wire logic [47:0] num,
	input  wire logic [31:0] den,
	// answer
	output logic             busy,
	output logic             done,
	output logic [47:0]      quot
);
	logic [32:0] rem_reg;
	logic [5:0]  cnt_reg;
	logic [32:0] shifted;
	logic [32:0] diff;

	// trial subtraction of the shifted remainder
	always_comb
	begin
		shifted = {rem_reg[31:0], quot[47]};
		diff    = shifted - {1'b0, den};
	end

	// iteration state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rem_reg <= 33'h0;
			quot    <= 48'h0;
			cnt_reg <= 6'h0;
			busy    <= 1'b0;
			done    <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && !busy)
			begin
				rem_reg <= 33'h0;
				quot    <= num;
				cnt_reg <= 6'h30;
				busy    <= 1'b1;
			end
			else if (busy)
			begin
				rem_reg <= diff[32] ? shifted : diff;
				quot    <= {quot[46:0], ~diff[32]};
				cnt_reg <= cnt_reg - 6'h1;
				busy    <= (cnt_reg != 6'h1);
				done    <= (cnt_reg == 6'h1);
			end
		end
	end
endmodule

/* File: shared/formatter_pkg.sv */
// constants shared by the measurement output formatter
package formatter_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_FORMAT    = 8'h00;
	localparam logic [7:0] OFS_TERM      = 8'h04;
	localparam logic [7:0] OFS_UNIT      = 8'h08;
	localparam logic [7:0] OFS_ALIM_LO   = 8'h0c;
	localparam logic [7:0] OFS_ALIM_HI   = 8'h10;
	localparam logic [7:0] OFS_WIN_START = 8'h14;
	localparam logic [7:0] OFS_WIN_END   = 8'h18;
	localparam logic [7:0] OFS_WIN_MODE  = 8'h1c;
	localparam logic [7:0] OFS_ANALOG    = 8'h20;
	localparam logic [7:0] OFS_DROPS     = 8'h24;
	localparam logic [7:0] OFS_STATUS    = 8'h28;
	// ----------------------------------------
	// fields, encodings and reset values
	// ----------------------------------------
	localparam int         FMT_LSB       = 0;
	localparam int         CONTENT_LSB   = 2;
	localparam logic [1:0] FMT_DEC       = 2'h0;
	localparam logic [1:0] FMT_HEX       = 2'h1;
	localparam logic [1:0] FMT_BIN       = 2'h2;
	localparam logic [31:0] UNIT_RST     = 32'h0000_2710; // 10000 um per bit
	localparam logic [31:0] ALIM_LO_RST  = 32'h0000_0000;
	localparam logic [31:0] ALIM_HI_RST  = 32'h0000_03e8; // 1000 mm
	localparam logic [31:0] WIN_START_RST = 32'hfffb_e1b0; // -269904 mm
	localparam logic [31:0] WIN_END_RST  = 32'h0004_1eb0;  // 270000 mm
	localparam logic [3:0]  TERM_RST     = 4'h1;
	localparam logic [31:0] TERM_MAX     = 32'h0000_0009;
	// ----------------------------------------
	// scaling and message layout
	// ----------------------------------------
	localparam logic [15:0] UM_PER_MM    = 16'h03e8;
	localparam logic [14:0] I_MIN_UA     = 15'h0fa0; // 4 mA
	localparam logic [14:0] I_SPAN_UA    = 15'h3e80; // 16 mA span
	localparam logic [7:0]  TEMP_OFFSET  = 8'h28;
	localparam logic [23:0] DEC_MAX      = 24'h98_967f;
	localparam int          DEC_DIGITS   = 7;
	localparam int          MSG_MAX      = 24;
	localparam logic [7:0]  CH_ZERO      = 8'h30;
	localparam logic [7:0]  CH_SEP       = 8'h20;
	localparam logic [7:0]  CH_MINUS     = 8'h2d;
	localparam logic [7:0]  CH_PLUS      = 8'h2b;
	localparam logic [7:0]  CH_LF        = 8'h0a;
endpackage

/* File: verification/host_receiver.sv */
// host model that takes the serial measurement bytes
`timescale 1ns/1ns
module host_receiver
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// byte stream
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	// stall control
	input  wire logic       slow
);
	logic [7:0] rx_q[$];
	// take a byte at each handshake; stall every other cycle when slow
	always @(posedge clk or posedge rst)
	begin
		if (rst)
			tx_ready <= 1'b0;
		else
		begin
			if (tx_valid && tx_ready)
				rx_q.push_back(tx_data);
			tx_ready <= slow ? !tx_ready : 1'b1;
		end
	end
endmodule

/* File: verification/testbench.sv */
// self-checking bench for the measurement output formatter
`timescale 1ns/1ns
module testbench;
	import formatter_pkg::*;
	logic        MCLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic        MEAS_VALID = 0, slow = 0, err, PREADY, PSLVERR, TX_VALID, TX_READY;
	logic        ANALOG_UPDATE;
	logic [7:0]  PADDR = 0, MEAS_STRENGTH = 0, MEAS_TEMP = 0, TX_DATA;
	logic [31:0] PWDATA = 0, MEAS_DIST = 0, rd, PRDATA;
	logic [14:0] ANALOG_UA;
	int          fails = 0, n_checks = 0, cyc = 0, n_upd = 0, u0;
	// ----------------------------------------
	// clock, instances, timeout
	// ----------------------------------------
	always #2 MCLK = ~MCLK;
	measurement_output_formatter dut_u (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEAS_VALID(MEAS_VALID),
		.MEAS_DIST(MEAS_DIST), .MEAS_STRENGTH(MEAS_STRENGTH), .MEAS_TEMP(MEAS_TEMP),
		.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
		.ANALOG_UA(ANALOG_UA), .ANALOG_UPDATE(ANALOG_UPDATE));
	host_receiver host_u (.clk(MCLK), .rst(RST), .tx_data(TX_DATA),
		.tx_valid(TX_VALID), .tx_ready(TX_READY), .slow(slow));
	// cycle ceiling and analogue update count
	always @(posedge MCLK)
	begin
		cyc++;
		if (ANALOG_UPDATE === 1'b1)
			n_upd++;
		if (cyc == 20000)
		begin
			fails++;
			finish_test();
		end
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer: setup, access until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		do @(posedge MCLK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check("register", rd, exp);
	endtask
	task meas(input logic [31:0] d, input logic [7:0] s, input logic [7:0] t);
		@(posedge MCLK);
		MEAS_VALID <= 1'b1;
		MEAS_DIST <= d;
		MEAS_STRENGTH <= s;
		MEAS_TEMP <= t;
		@(posedge MCLK);
		MEAS_VALID <= 1'b0;
	endtask
	// collect a whole frame at the host and compare it byte by byte
	task frame(input string s);
		int i;
		repeat (60) @(posedge MCLK);
		i = 0;
		while (host_u.rx_q.size() < s.len() && i < 2000)
		begin
			@(posedge MCLK);
			i++;
		end
		repeat (20) @(posedge MCLK);
		check("frame length", 32'(host_u.rx_q.size()), 32'(s.len()));
		for (i = 0; i < s.len() && i < host_u.rx_q.size(); i++)
			check("frame byte", {24'h0, host_u.rx_q[i]}, {24'h0, s[i]});
		host_u.rx_q.delete();
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial
	begin
		repeat (16) @(posedge MCLK);
		RST <= 1'b0;
		rdc(OFS_FORMAT, 32'h0);
		rdc(OFS_TERM, 32'h1);
		rdc(OFS_UNIT, 32'h2710);
		wr(OFS_TERM, 32'ha);
		rdc(OFS_TERM, 32'h1);
		apb(1'b0, 8'h2c, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		rdc(OFS_STATUS, 32'h0);
		$display("test settings done");
		wr(OFS_TERM, 32'h0);
		wr(OFS_FORMAT, 32'hc);
		meas(32'd500, 8'd200, -8'sd25);
		frame("+0000500 200 -025\r\n");
		check("analogue updates", 32'(n_upd), 32'd1);
		rdc(OFS_ANALOG, 32'd12000);
		check("analogue port", {17'h0, ANALOG_UA}, 32'd12000);
		wr(OFS_TERM, 32'h7);
		wr(OFS_FORMAT, 32'hd);
		slow <= 1'b1;
		meas(-32'sd2, 8'd1, 8'd1);
		frame("FFFFFFFE 01 01,");
		rdc(OFS_ANALOG, 32'd4000);
		slow <= 1'b0;
		$display("test ascii done");
		wr(OFS_FORMAT, 32'he);
		meas(32'd3380, 8'd44, 8'd53);
		frame("\x82\x52\x16\x5d");
		wr(OFS_UNIT, 32'd1000);
		meas(-32'sd5, 8'd2, 8'd0);
		frame("\xff\x7b\x01\x28");
		$display("test binary done");
		wr(OFS_FORMAT, 32'h0);
		wr(OFS_ALIM_LO, 32'd1000);
		wr(OFS_ALIM_HI, 32'd0);
		meas(32'd250, 8'd1, 8'd1);
		frame("+0000250,");
		rdc(OFS_ANALOG, 32'd16000);
		wr(OFS_ALIM_LO, 32'd5);
		wr(OFS_ALIM_HI, 32'd5);
		rdc(OFS_ALIM_LO, 32'd1000);
		rdc(OFS_ALIM_HI, 32'd0);
		$display("test analogue done");
		wr(OFS_WIN_END, 32'd100);
		u0 = n_upd;
		meas(32'd200, 8'd1, 8'd1);
		frame("ERR,");
		check("analogue updates", 32'(n_upd), 32'(u0));
		wr(OFS_WIN_MODE, 32'h1);
		meas(32'd200, 8'd1, 8'd1);
		frame("");
		meas(32'd50, 8'd1, 8'd1);
		meas(32'd60, 8'd1, 8'd1);
		rdc(OFS_STATUS, 32'h3);
		frame("+0000050,");
		rdc(OFS_DROPS, 32'h1);
		rdc(OFS_STATUS, 32'h0);
		$display("test window and drops done");
		finish_test();
	end
endmodule
